//--- common/secp_pkg.sv
// Package: constants and types for the command parser
package secp_pkg;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RXBYTE = 12'h008;
  localparam logic [11:0] REG_HDR = 12'h00C;
  localparam logic [11:0] REG_POLICY = 12'h010;
  localparam logic [11:0] REG_DONE = 12'h014;
  // Control field positions
  localparam int CTRL_I2C = 0;
  localparam int CTRL_LCFG = 1;
  localparam int CTRL_LVAL = 2;
  localparam int CTRL_LEGACY = 3;
  localparam int CTRL_OTPWR = 4;
  localparam int CTRL_STARTSTOP = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] POLICY_RESET = 16'h0000;
  // Packet layout
  localparam logic [7:0] IDX_COUNT = 8'h01;
  localparam logic [7:0] IDX_OPCODE = 8'h02;
  localparam logic [7:0] IDX_P1 = 8'h03;
  localparam logic [7:0] IDX_P2LO = 8'h04;
  localparam logic [7:0] IDX_P2HI = 8'h05;
  localparam logic [7:0] MIN_COUNT = 8'h07;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // Opcodes
  localparam logic [7:0] OP_KEYDERIV = 8'h1C;
  localparam logic [7:0] OP_DIGEST = 8'h15;
  localparam logic [7:0] OP_KEYEDHASH = 8'h11;
  localparam logic [7:0] OP_MACVERIFY = 8'h28;
  localparam logic [7:0] OP_LOCK = 8'h17;
  localparam logic [7:0] OP_MACRESP = 8'h08;
  localparam logic [7:0] OP_NONCE = 8'h16;
  localparam logic [7:0] OP_RANDOM = 8'h1B;
  localparam logic [7:0] OP_SHA = 8'h47;
  localparam logic [7:0] OP_READ = 8'h02;
  localparam logic [7:0] OP_WRITE = 8'h12;
  localparam logic [7:0] OP_UPDATE = 8'h20;
  localparam logic [7:0] OP_REVISION = 8'h30;
  localparam logic [7:0] OP_PAUSE = 8'h01;
  // Zones
  localparam logic [7:0] ZONE_CONFIG = 8'h00;
  localparam logic [7:0] ZONE_OTP = 8'h01;
  localparam logic [7:0] ZONE_DATA = 8'h02;
  // Status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_PARSE = 8'h03;
  localparam logic [7:0] ST_EXEC = 8'h0F;
  localparam logic [7:0] ST_COMM = 8'hFF;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_US = 1300;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int WATCHDOG_MS = 1300;
  localparam int WATCHDOG_CYC = WATCHDOG_MS * 1000 * CLK_MHZ;
  localparam int EXEC_CYC = 16;
  localparam logic [4:0] CMD_NONE = 5'h00;
  typedef enum logic [4:0] {
    SP_IDLE = 5'b00001,
    SP_RECV = 5'b00010,
    SP_CHECK = 5'b00100,
    SP_BUSY = 5'b01000,
    SP_SLEEP = 5'b10000
  } secp_state_e;
endpackage

//--- design/secp_parser.sv
// Command packet parser with APB register access
`timescale 1ns/100ps
module secp_parser #(
  parameter int TimeoutCyc = secp_pkg::TIMEOUT_CYC,
  parameter int WatchdogCyc = secp_pkg::WATCHDOG_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy_q,
  output logic sleep_q,
  output logic [7:0] status_q,
  output logic [4:0] cmdSel_q
);
  import secp_pkg::*;

  secp_state_e state_q;
  logic [5:0] ctrl_q;
  logic [15:0] policy_q;
  logic [7:0] count_q, idx_q, opcode_q, first_parameter_q;
  logic [15:0] second_parameter_q, crc_q, rxCrc_q;
  logic [31:0] timer_q, wdog_q;
  logic [7:0] execCnt_q;
  logic doneFlag_q;
  logic [31:0] rdData_d;
  logic apbSetup, apbWr, apbRd, byteWr, doneClr;
  logic [7:0] rxByte;
  logic [15:0] crcNext;
  logic known, lenBad, zoneBad, accessBad;
  logic [4:0] sel;
  logic hideRd;

  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign rxByte = pwdata[7:0];
  assign byteWr = apbWr && paddr == REG_RXBYTE;
  assign doneClr = apbWr && paddr == REG_DONE;
  assign hideRd = busy_q || state_q == SP_CHECK;

  // CRC over one byte, LSB first, shift-left form
  always_comb begin
    crcNext = crc_q;
    for (int i = 0; i < 8; i++) begin
      if (rxByte[i] ^ crcNext[15]) begin
        crcNext = {crcNext[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        crcNext = {crcNext[14:0], 1'b0};
      end
    end
  end

  // Opcode decode
  always_comb begin
    known = 1'b1;
    sel = CMD_NONE;
    case (opcode_q)
      OP_KEYDERIV: sel = 5'h01;
      OP_DIGEST: sel = 5'h02;
      OP_KEYEDHASH: sel = 5'h03;
      OP_MACVERIFY: sel = 5'h04;
      OP_LOCK: sel = 5'h05;
      OP_MACRESP: sel = 5'h06;
      OP_NONCE: sel = 5'h07;
      OP_RANDOM: sel = 5'h08;
      OP_SHA: sel = 5'h09;
      OP_READ: sel = 5'h0A;
      OP_WRITE: sel = 5'h0B;
      OP_UPDATE: sel = 5'h0C;
      OP_REVISION: sel = 5'h0D;
      OP_PAUSE: sel = 5'h0E;
      default: known = 1'b0;
    endcase
  end

  // Length check only for fixed-size commands; others proceed silently
  always_comb begin
    lenBad = 1'b0;
    if (opcode_q == OP_READ || opcode_q == OP_REVISION ||
        opcode_q == OP_PAUSE) begin
      lenBad = count_q != MIN_COUNT;
    end
  end

  // Zone gating for read and write
  always_comb begin
    zoneBad = 1'b0;
    accessBad = 1'b0;
    if (opcode_q == OP_READ || opcode_q == OP_WRITE) begin
      zoneBad = first_parameter_q[1:0] == 2'b11 ||
                first_parameter_q[5:2] != 4'h0;
    end
    if (opcode_q == OP_READ && first_parameter_q[1:0] == ZONE_OTP[1:0]) begin
      accessBad = !ctrl_q[CTRL_LCFG] ||
                  ctrl_q[CTRL_LEGACY];
    end
    if (opcode_q == OP_WRITE) begin
      case (first_parameter_q[1:0])
        ZONE_CONFIG[1:0]:
          accessBad = ctrl_q[CTRL_LCFG] ||
                      first_parameter_q[6];
        ZONE_OTP[1:0]:
          accessBad = !ctrl_q[CTRL_LCFG] || (ctrl_q[CTRL_LVAL] &&
                      !ctrl_q[CTRL_OTPWR]);
        ZONE_DATA[1:0]:
          accessBad = !ctrl_q[CTRL_LCFG] || (ctrl_q[CTRL_LVAL] &&
                      !policy_q[second_parameter_q[6:3]]);
        default: accessBad = 1'b0;
      endcase
    end
  end

  // Main sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= SP_IDLE;
      idx_q <= 8'h00;
      count_q <= 8'h00;
      opcode_q <= 8'h00;
      first_parameter_q <= 8'h00;
      second_parameter_q <= 16'h0000;
      crc_q <= CRC_INIT;
      rxCrc_q <= 16'h0000;
      timer_q <= 32'h0000_0000;
      wdog_q <= 32'h0000_0000;
      execCnt_q <= 8'h00;
      status_q <= ST_OK;
      cmdSel_q <= CMD_NONE;
    end else begin
      case (state_q)
        SP_IDLE: begin
          if (byteWr) begin
            state_q <= SP_RECV;
            idx_q <= IDX_COUNT;
            crc_q <= CRC_INIT;
            timer_q <= 32'h0000_0000;
            wdog_q <= 32'h0000_0000;
          end
        end
        SP_RECV: begin
          timer_q <= byteWr ? 32'h0000_0000 : timer_q + 32'h0000_0001;
          wdog_q <= wdog_q + 32'h0000_0001;
          if (byteWr) begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == IDX_COUNT) begin
              count_q <= rxByte;
            end
            if (idx_q == IDX_OPCODE) begin
              opcode_q <= rxByte;
            end
            if (idx_q == IDX_P1) begin
              first_parameter_q <= rxByte;
            end
            if (idx_q == IDX_P2LO) begin
              second_parameter_q[7:0] <= rxByte;
            end
            if (idx_q == IDX_P2HI) begin
              second_parameter_q[15:8] <= rxByte;
            end
            if (idx_q + 8'h01 < count_q || idx_q < IDX_OPCODE) begin
              crc_q <= crcNext;
            end else if (idx_q + 8'h01 == count_q) begin
              rxCrc_q[7:0] <= rxByte;
            end else begin
              rxCrc_q[15:8] <= rxByte;
            end
            if (idx_q >= IDX_OPCODE && idx_q == count_q) begin
              state_q <= SP_CHECK;
            end
          end else if (!ctrl_q[CTRL_I2C] && timer_q >= TimeoutCyc) begin
            state_q <= SP_SLEEP;
          end else if (ctrl_q[CTRL_I2C] && (wdog_q >= WatchdogCyc ||
                       ctrl_q[CTRL_STARTSTOP])) begin
            state_q <= SP_IDLE;
          end
        end
        SP_CHECK: begin
          state_q <= SP_BUSY;
          execCnt_q <= 8'h00;
          cmdSel_q <= sel;
          if (count_q < MIN_COUNT || crc_q != rxCrc_q) begin
            status_q <= ST_COMM;
            cmdSel_q <= CMD_NONE;
          end else if (!known || lenBad || zoneBad) begin
            status_q <= ST_PARSE;
          end else if (accessBad) begin
            status_q <= ST_EXEC;
          end else begin
            status_q <= ST_OK;
          end
        end
        SP_BUSY: begin
          execCnt_q <= execCnt_q + 8'h01;
          if (execCnt_q == 8'(EXEC_CYC - 1)) begin
            state_q <= SP_IDLE;
            cmdSel_q <= CMD_NONE;
          end
        end
        SP_SLEEP: begin
          if (apbWr && paddr == REG_CTRL) begin
            state_q <= SP_IDLE;
          end
        end
        default: state_q <= SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      busy_q <= state_q == SP_CHECK || (state_q == SP_BUSY &&
                execCnt_q != 8'(EXEC_CYC - 1));
      sleep_q <= state_q == SP_SLEEP ||
                 (state_q == SP_RECV && !byteWr && !ctrl_q[CTRL_I2C] &&
                  timer_q >= TimeoutCyc);
    end
  end

  // Completion flag, set wins over clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      doneFlag_q <= 1'b0;
    end else if (state_q == SP_BUSY && execCnt_q == 8'(EXEC_CYC - 1)) begin
      doneFlag_q <= 1'b1;
    end else if (doneClr) begin
      doneFlag_q <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
      policy_q <= POLICY_RESET;
    end else if (apbWr && paddr == REG_CTRL) begin
      ctrl_q <= pwdata[5:0];
    end else if (apbWr && paddr == REG_POLICY) begin
      policy_q <= pwdata[15:0];
    end
  end

  // Read mux; status hidden while busy
  always_comb begin
    case (paddr)
      REG_CTRL: rdData_d = {26'h0, ctrl_q};
      REG_STATUS: rdData_d = hideRd ? 32'h0000_0000 :
                  {19'h0, sleep_q, busy_q, doneFlag_q, 2'b00,
                   status_q};
      REG_HDR: rdData_d = hideRd ? 32'h0000_0000 :
               {opcode_q, first_parameter_q, second_parameter_q};
      REG_POLICY: rdData_d = {16'h0, policy_q};
      REG_DONE: rdData_d = {31'h0, doneFlag_q};
      default: rdData_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbSetup;
      pslverr <= 1'b0;
      if (apbSetup && !pwrite) begin
        prdata <= rdData_d;
      end
      if (apbSetup && !(paddr == REG_CTRL || paddr == REG_STATUS ||
          paddr == REG_RXBYTE || paddr == REG_HDR ||
          paddr == REG_POLICY || paddr == REG_DONE)) begin
        pslverr <= 1'b1;
      end
    end
  end

  a_busy_ignores: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_BUSY && byteWr |=> state_q != SP_RECV)
    else $error("byte accepted while busy");
  a_crc_first: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_CHECK && crc_q != rxCrc_q |=> status_q == ST_COMM)
    else $error("crc error not reported first");
  sequence s_lastByte;
    state_q == SP_RECV && byteWr && idx_q >= IDX_OPCODE && idx_q == count_q;
  endsequence
  a_busy_entry: assert property (
    @(posedge clk) disable iff (!resetn)
    s_lastByte |=> state_q == SP_CHECK ##1 busy_q)
    else $error("busy not entered after last byte");
  a_busy_bounded: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(busy_q) |-> ##[1:20] !busy_q)
    else $error("busy too long");
  a_unknown_parse: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_CHECK && crc_q == rxCrc_q && count_q >= MIN_COUNT &&
    !known |=> status_q == ST_PARSE)
    else $error("unknown opcode not parse error");
  a_otp_read: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_CHECK && opcode_q == OP_READ && !zoneBad &&
    first_parameter_q[1:0] == 2'b01 && !ctrl_q[CTRL_LCFG] |-> accessBad)
    else $error("otp read allowed while unlocked");
  a_write_gate: assert property (
    @(posedge clk) disable iff (!resetn)
    opcode_q == OP_WRITE && first_parameter_q[1:0] == 2'b10 &&
    !ctrl_q[CTRL_LCFG] |-> accessBad)
    else $error("data write allowed before config lock");
  a_sleep_timeout: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_RECV && !byteWr && !ctrl_q[CTRL_I2C] &&
    timer_q >= TimeoutCyc |=> sleep_q && state_q == SP_SLEEP)
    else $error("no sleep after timeout");
  a_i2c_abort: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_RECV && !byteWr && ctrl_q[CTRL_I2C] &&
    ctrl_q[CTRL_STARTSTOP] |=> state_q == SP_IDLE)
    else $error("start/stop did not abort");
  a_flag_skipped: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_IDLE && byteWr |=> state_q == SP_RECV &&
    idx_q == IDX_COUNT && crc_q == CRC_INIT)
    else $error("flag byte not skipped");
  a_len_parse: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_CHECK && crc_q == rxCrc_q && count_q >= MIN_COUNT &&
    known && lenBad |=> status_q == ST_PARSE)
    else $error("wrong length not parse error");
  a_config_write: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_CHECK && opcode_q == OP_WRITE &&
    first_parameter_q[1:0] == 2'b00 &&
    (ctrl_q[CTRL_LCFG] || first_parameter_q[6]) |-> accessBad)
    else $error("config write allowed when locked or encrypted");
  a_slot_policy: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_CHECK && opcode_q == OP_WRITE &&
    first_parameter_q[1:0] == 2'b10 && ctrl_q[CTRL_LCFG] &&
    ctrl_q[CTRL_LVAL] |-> accessBad == !policy_q[second_parameter_q[6:3]])
    else $error("data write ignores slot policy");
  a_wdog_abort: assert property (
    @(posedge clk) disable iff (!resetn)
    state_q == SP_RECV && !byteWr && ctrl_q[CTRL_I2C] &&
    wdog_q >= WatchdogCyc |=> state_q == SP_IDLE && !sleep_q)
    else $error("watchdog did not abort");
  a_status_hidden: assert property (
    @(posedge clk) disable iff (!resetn)
    apbSetup && !pwrite && paddr == REG_STATUS &&
    (state_q == SP_CHECK || state_q == SP_BUSY) |=> prdata == 32'h0000_0000)
    else $error("status readable while busy");
  a_cmd_cleared: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(busy_q) |-> cmdSel_q == CMD_NONE)
    else $error("command index kept after busy");
endmodule

//--- tb/secp_host.sv
// Host model: APB master that frames and sends command packets
`timescale 1ns/100ps
module secp_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import secp_pkg::*;
  logic [31:0] rdat;
  logic rerr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer; address and data lines inverted once released
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[15] ^ b[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  // Flag, count, opcode, params, data, checksum low then high
  task automatic pkt(input logic [7:0] op, input logic [7:0] p1,
                     input logic [15:0] p2, input int nd, input logic bad);
    logic [7:0] b[$];
    logic [15:0] c;
    c = CRC_INIT;
    b = '{MIN_COUNT + 8'(nd), op, p1, p2[7:0], p2[15:8]};
    for (int i = 0; i < nd; i++) begin
      b.push_back(8'(i));
    end
    foreach (b[i]) c = crc_step(c, b[i]);
    c = c ^ {15'h0000, bad};
    b.push_front(8'h03);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) xfer(1'b1, REG_RXBYTE, {24'h00_0000, b[i]});
  endtask
endmodule

//--- tb/secp_parser_test.sv
// Testbench for the command packet parser
`timescale 1ns/100ps
module secp_parser_test;
  import secp_pkg::*;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] op;
    logic [7:0] p1;
    logic [15:0] p2;
    logic [15:0] pol;
    logic [3:0] nd;
    logic [7:0] st;
    logic [4:0] sel;
  } secp_row_s;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic busy_q, sleep_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] status_q;
  logic [4:0] cmdSel_q;
  int num_errors = 0;
  int check_count = 0;
  // Control, opcode, zone, address, policy, data count, status, index
  secp_row_s rows [28] = '{
    '{8'h00,8'h1C,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h01},
    '{8'h00,8'h15,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h02},
    '{8'h00,8'h11,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h03},
    '{8'h00,8'h28,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h04},
    '{8'h00,8'h17,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h05},
    '{8'h00,8'h08,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h06},
    '{8'h00,8'h16,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h07},
    '{8'h00,8'h1B,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h08},
    '{8'h00,8'h47,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h09},
    '{8'h00,8'h02,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h0A},
    '{8'h02,8'h12,8'h02,16'h0008,16'h0000,4'h4,8'h00,5'h0B},
    '{8'h00,8'h20,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h0C},
    '{8'h00,8'h30,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h0D},
    '{8'h00,8'h01,8'h00,16'h0000,16'h0000,4'h0,8'h00,5'h0E},
    '{8'h00,8'h02,8'h01,16'h0000,16'h0000,4'h0,8'h0F,5'h0A},
    '{8'h02,8'h02,8'h01,16'h0000,16'h0000,4'h0,8'h00,5'h0A},
    '{8'h0A,8'h02,8'h01,16'h0000,16'h0000,4'h0,8'h0F,5'h0A},
    '{8'h00,8'h12,8'h02,16'h0008,16'h0000,4'h4,8'h0F,5'h0B},
    '{8'h02,8'h12,8'h00,16'h0010,16'h0000,4'h4,8'h0F,5'h0B},
    '{8'h06,8'h12,8'h02,16'h0008,16'h0000,4'h4,8'h0F,5'h0B},
    '{8'h06,8'h12,8'h02,16'h0008,16'h0002,4'h4,8'h00,5'h0B},
    '{8'h06,8'h12,8'h01,16'h0000,16'h0000,4'h4,8'h0F,5'h0B},
    '{8'h16,8'h12,8'h01,16'h0000,16'h0000,4'h4,8'h00,5'h0B},
    '{8'h00,8'h30,8'h00,16'h0000,16'h0000,4'h1,8'h03,5'h0D},
    '{8'h00,8'h02,8'h03,16'h0000,16'h0000,4'h0,8'h03,5'h0A},
    '{8'h00,8'h55,8'h00,16'h0000,16'h0000,4'h0,8'h03,5'h00},
    '{8'h00,8'h12,8'h00,16'h0010,16'h0000,4'h4,8'h00,5'h0B},
    '{8'h00,8'h12,8'h40,16'h0010,16'h0000,4'h4,8'h0F,5'h0B}
  };
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  secp_parser #(.TimeoutCyc(50), .WatchdogCyc(200)) u_secp_parser (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy_q(busy_q),
    .sleep_q(sleep_q), .status_q(status_q), .cmdSel_q(cmdSel_q)
  );
  secp_host u_secp_host (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_secp_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    u_secp_host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  // Busy phase, host polling, then final status
  task automatic run(input logic [7:0] st, input logic [4:0] sel);
    int n;
    n = 0;
    while (busy_q !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk("busy", 32'h1, 32'(busy_q));
    chk("cmdSel", 32'(sel), 32'(cmdSel_q));
    rd(REG_STATUS);
    chk("status while busy", 32'h0, u_secp_host.rdat);
    wr(REG_RXBYTE, 32'h0000_0003);
    n = 0;
    do begin
      rd(REG_DONE);
      n++;
    end while (u_secp_host.rdat[0] !== 1'b1 && n < 20);
    chk("done", 32'h1, 32'(u_secp_host.rdat[0]));
    wr(REG_DONE, 32'h0000_0001);
    chk("status", 32'(st), 32'(status_q));
    chk("cmdSel idle", 32'h0, 32'(cmdSel_q));
  endtask
  initial begin
    resetn = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("reset outs", 32'h0,
        {17'h0_0000, busy_q, sleep_q, status_q, cmdSel_q});
    rd(REG_CTRL);
    chk("ctrl reset", 32'(CTRL_RESET), u_secp_host.rdat);
    rd(REG_POLICY);
    chk("policy reset", 32'(POLICY_RESET), u_secp_host.rdat);
    rd(12'h018);
    chk("unmapped err", 32'h1, 32'(u_secp_host.rerr));
    chk("unmapped data", 32'h0, u_secp_host.rdat);
    foreach (rows[i]) begin
      wr(REG_CTRL, 32'(rows[i].ctl));
      wr(REG_POLICY, 32'(rows[i].pol));
      u_secp_host.pkt(rows[i].op, rows[i].p1, rows[i].p2,
                      int'(rows[i].nd), 1'b0);
      run(rows[i].st, rows[i].sel);
    end
    // Bad checksum on a wrong-length block
    wr(REG_CTRL, 32'h0000_0000);
    u_secp_host.pkt(OP_REVISION, 8'h00, 16'h0000, 1, 1'b1);
    repeat (18) @(posedge clk);
    chk("crc status", 32'(ST_COMM), 32'(status_q));
    wr(REG_DONE, 32'h0000_0001);
    // Short block in single-wire mode
    wr(REG_RXBYTE, 32'h0000_0003);
    wr(REG_RXBYTE, 32'h0000_0007);
    repeat (60) @(posedge clk);
    chk("sleep", 32'h1, 32'(sleep_q));
    wr(REG_CTRL, 32'h0000_0001);
    // Short block in I2C mode, then start/stop abort
    wr(REG_RXBYTE, 32'h0000_0003);
    wr(REG_RXBYTE, 32'h0000_0007);
    repeat (60) @(posedge clk);
    chk("no sleep i2c", 32'h0, 32'(sleep_q));
    wr(REG_CTRL, 32'h0000_0021);
    wr(REG_CTRL, 32'h0000_0001);
    u_secp_host.pkt(OP_READ, ZONE_CONFIG, 16'h0000, 0, 1'b0);
    run(ST_OK, 5'h0A);
    // Short block in I2C mode, then watchdog abort
    wr(REG_RXBYTE, 32'h0000_0003);
    wr(REG_RXBYTE, 32'h0000_0007);
    repeat (220) @(posedge clk);
    chk("no sleep wdog", 32'h0, 32'(sleep_q));
    u_secp_host.pkt(OP_READ, ZONE_CONFIG, 16'h0000, 0, 1'b0);
    run(ST_OK, 5'h0A);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("Error watchdog expected finish seen hang");
    test_done();
  end
endmodule
